// [core/timer_channel_status_flags_regs.svh]
// Register offsets, field positions, reset values and counts of the timer channel.
`ifndef TIMER_CHANNEL_STATUS_FLAGS_REGS_SVH
`define TIMER_CHANNEL_STATUS_FLAGS_REGS_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define OFF_CTRL 32'h0000_0000
`define OFF_COUNT 32'h0000_0004
`define OFF_GRB 32'h0000_0008
`define OFF_STATUS 32'h0000_000C
`define OFF_IRQ_STAT 32'h0000_0010
`define OFF_IRQ_CLR 32'h0000_0014
`define OFF_IRQ_EN 32'h0000_0018

// ****************************************************************
// Control register fields.
// ****************************************************************
`define CTRL_RUN_BIT 0
`define CTRL_MODE_LSB 1
`define CTRL_MODE_MSB 2
`define CTRL_CAPTURE_BIT 3
`define CTRL_TRANSFER_DISABLE_SELECT_BIT 4
`define CTRL_WIDTH 5
`define CTRL_RST 5'h00

// ****************************************************************
// Status register fields.
// ****************************************************************
`define STAT_MATCH_BIT 1
`define STAT_OVF_BIT 4
`define STAT_UNF_BIT 5
`define STAT_DIR_BIT 7
`define DIR_RST 1'b1

// ****************************************************************
// Interrupt register fields and counter values.
// ****************************************************************
`define IRQ_MATCH 0
`define IRQ_OVF 1
`define IRQ_UNF 2
`define NUM_FLAGS 3
`define COUNT_MAX 16'hFFFF
`define COUNT_ZERO 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [core/timer_channel_pkg.sv]
// Types shared by the timer channel and its register port.
package timer_channel_pkg;

  typedef enum logic [1:0]
  {
    MODE_UP = 2'b00,
    MODE_PHASE = 2'b01,
    MODE_CASCADE = 2'b10
  } count_mode_t;

  typedef struct packed
  {
    logic [31:0] addr;
    logic [2:0] prot;
  } axil_addr_t;

  typedef struct packed
  {
    logic [31:0] data;
    logic [3:0] strb;
  } axil_wdata_t;

  typedef struct packed
  {
    logic en;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } reg_write_t;

endpackage : timer_channel_pkg

// [core/axil_reg_port.sv]
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/10ps
`include "timer_channel_status_flags_regs.svh"
module axil_reg_port
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic awvalid_i,
  input timer_channel_pkg::axil_addr_t aw_i,
  output logic awready_o,
  input wire logic wvalid_i,
  input timer_channel_pkg::axil_wdata_t w_i,
  output logic wready_o,
  output logic bvalid_o,
  output logic [1:0] bresp_o,
  input wire logic bready_i,
  input wire logic arvalid_i,
  input timer_channel_pkg::axil_addr_t ar_i,
  output logic arready_o,
  output logic rvalid_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  input wire logic rready_i,
  output timer_channel_pkg::reg_write_t wr_o,
  input wire logic wr_ok_i,
  output logic rd_en_o,
  output logic [31:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_ok_i
);

  logic [31:0] awaddr_reg;
  timer_channel_pkg::axil_wdata_t wdata_reg;
  logic fire;

  // ****************************************************************
  // Write path.
  // ****************************************************************
  assign fire = !awready_o && !wready_o && !bvalid_o;
  assign wr_o = '{en: fire, addr: awaddr_reg, data: wdata_reg.data, strb: wdata_reg.strb};

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      awready_o <= 1'b1;
      wready_o <= 1'b1;
      awaddr_reg <= 32'h0000_0000;
      wdata_reg <= '0;
      bvalid_o <= 1'b0;
      bresp_o <= `RESP_OKAY;
    end
    else
    begin
      if (awvalid_i && awready_o)
      begin
        awready_o <= 1'b0;
        awaddr_reg <= aw_i.addr;
      end
      if (wvalid_i && wready_o)
      begin
        wready_o <= 1'b0;
        wdata_reg <= w_i;
      end
      if (fire)
      begin
        bvalid_o <= 1'b1;
        bresp_o <= wr_ok_i ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_o && bready_i)
      begin
        bvalid_o <= 1'b0;
        awready_o <= 1'b1;
        wready_o <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Read path.
  // ****************************************************************
  assign rd_en_o = arvalid_i && arready_o;
  assign rd_addr_o = ar_i.addr;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      arready_o <= 1'b1;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      rresp_o <= `RESP_OKAY;
    end
    else if (rd_en_o)
    begin
      arready_o <= 1'b0;
      rvalid_o <= 1'b1;
      rdata_o <= rd_ok_i ? rd_data_i : 32'h0000_0000;
      rresp_o <= rd_ok_i ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid_o && rready_i)
    begin
      rvalid_o <= 1'b0;
      arready_o <= 1'b1;
    end
  end

endmodule : axil_reg_port

// [core/timer_channel_status_flags.sv]
// Timer channel with count, general register B, status flags and interrupt logic.
`timescale 1ns/10ps
`include "timer_channel_status_flags_regs.svh"

// Summary of operation
// (RULE1) With register B in compare use, the match flag is set while the count equals register B.
// (RULE2) With register B in capture use, a capture event copies the count into B and sets the match flag.
// (RULE3) The overflow flag is set when the count steps up from FFFF to 0000.
// (RULE4) The underflow flag is set when the count steps down from 0000 to FFFF.
// (RULE5) Match, overflow and underflow flags clear on a 0 written after reading them as 1, the match flag also by RULE8; a 1 does nothing.
// (RULE6) The count goes up and down only in phase counting or cascade mode, otherwise only up; the code does not count at all in mode 2'b11.
// (RULE7) The read-only direction flag shows 1 after an up step and 0 after a down step.
// (RULE8) The match flag also clears when the transfer controller is started by the match interrupt with disable-select 0.
module timer_channel_status_flags
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic s_axi_awvalid_i,
  input timer_channel_pkg::axil_addr_t s_axi_aw_i,
  output logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input timer_channel_pkg::axil_wdata_t s_axi_w_i,
  output logic s_axi_wready_o,
  output logic s_axi_bvalid_o,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input timer_channel_pkg::axil_addr_t s_axi_ar_i,
  output logic s_axi_arready_o,
  output logic s_axi_rvalid_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rready_i,
  input wire logic capture_i,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire logic cascade_ovf_i,
  input wire logic cascade_unf_i,
  input wire logic transfer_activate_i,
  output logic match_b_interrupt_o,
  output logic irq_o
);

  timer_channel_pkg::reg_write_t wr;
  timer_channel_pkg::count_mode_t mode;
  logic wr_ok, rd_en, rd_ok, capture_evt, count_direction_flag;
  logic step_up, step_dn, phase_a_reg, phase_b_reg;
  logic [31:0] rd_addr, rd_data, status_word;
  logic [`CTRL_WIDTH-1:0] ctrl_reg;
  logic [15:0] timer_count, general_reg_b;
  logic [`NUM_FLAGS-1:0] flag_set, flag_reg, armed_reg, irq_stat_reg, irq_en_reg;

  function automatic logic hit(input logic [31:0] addr, input logic [31:0] off);
    hit = (addr == off);
  endfunction : hit
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        merge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction : merge
  function automatic int flag_pos(input int idx);
    unique case (idx)
      `IRQ_MATCH: flag_pos = `STAT_MATCH_BIT;
      `IRQ_OVF: flag_pos = `STAT_OVF_BIT;
      default: flag_pos = `STAT_UNF_BIT;
    endcase
  endfunction : flag_pos

  // ****************************************************************
  // Register bus port.
  // ****************************************************************
  axil_reg_port u_port
  (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .awvalid_i(s_axi_awvalid_i), .aw_i(s_axi_aw_i),
    .awready_o(s_axi_awready_o), .wvalid_i(s_axi_wvalid_i),
    .w_i(s_axi_w_i), .wready_o(s_axi_wready_o),
    .bvalid_o(s_axi_bvalid_o), .bresp_o(s_axi_bresp_o),
    .bready_i(s_axi_bready_i), .arvalid_i(s_axi_arvalid_i),
    .ar_i(s_axi_ar_i), .arready_o(s_axi_arready_o),
    .rvalid_o(s_axi_rvalid_o), .rdata_o(s_axi_rdata_o),
    .rresp_o(s_axi_rresp_o), .rready_i(s_axi_rready_i),
    .wr_o(wr), .wr_ok_i(wr_ok),
    .rd_en_o(rd_en), .rd_addr_o(rd_addr),
    .rd_data_i(rd_data), .rd_ok_i(rd_ok)
  );

  assign wr_ok = hit(wr.addr, `OFF_CTRL) || hit(wr.addr, `OFF_COUNT) ||
                 hit(wr.addr, `OFF_GRB) || hit(wr.addr, `OFF_STATUS) ||
                 hit(wr.addr, `OFF_IRQ_STAT) || hit(wr.addr, `OFF_IRQ_CLR) ||
                 hit(wr.addr, `OFF_IRQ_EN);

  // ****************************************************************
  // Read data selection.
  // ****************************************************************
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`STAT_DIR_BIT] = count_direction_flag; // RULE7
    for (int i = 0; i < `NUM_FLAGS; i++)
    begin
      status_word[flag_pos(i)] = flag_reg[i];
    end
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (hit(rd_addr, `OFF_CTRL))
      rd_data[`CTRL_WIDTH-1:0] = ctrl_reg;
    else if (hit(rd_addr, `OFF_COUNT))
      rd_data[15:0] = timer_count;
    else if (hit(rd_addr, `OFF_GRB))
      rd_data[15:0] = general_reg_b;
    else if (hit(rd_addr, `OFF_STATUS))
      rd_data = status_word;
    else if (hit(rd_addr, `OFF_IRQ_STAT))
      rd_data[`NUM_FLAGS-1:0] = irq_stat_reg;
    else if (hit(rd_addr, `OFF_IRQ_EN))
      rd_data[`NUM_FLAGS-1:0] = irq_en_reg;
    else if (!hit(rd_addr, `OFF_IRQ_CLR))
      rd_ok = 1'b0;
  end

  // ****************************************************************
  // Control register.
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ctrl_reg <= `CTRL_RST;
    else if (wr.en && hit(wr.addr, `OFF_CTRL))
      ctrl_reg <= `CTRL_WIDTH'(merge({27'h0, ctrl_reg}, wr.data, wr.strb));
  end

  assign mode = timer_channel_pkg::count_mode_t'(ctrl_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);

  // ****************************************************************
  // Count step decode.
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      {phase_a_reg, phase_b_reg} <= 2'b00;
    else
      {phase_a_reg, phase_b_reg} <= {phase_a_i, phase_b_i};
  end

  always_comb
  begin
    step_up = 1'b0;
    step_dn = 1'b0;
    if (ctrl_reg[`CTRL_RUN_BIT])
    begin
      case (mode)
        timer_channel_pkg::MODE_UP: step_up = 1'b1; // RULE6
        timer_channel_pkg::MODE_PHASE:
          if ((phase_a_i != phase_a_reg) ^ (phase_b_i != phase_b_reg))
          begin
            step_up = !(phase_a_reg ^ phase_b_i); // RULE6
            step_dn = phase_a_reg ^ phase_b_i;
          end
        timer_channel_pkg::MODE_CASCADE:
        begin
          step_up = cascade_ovf_i && !cascade_unf_i; // RULE6
          step_dn = cascade_unf_i && !cascade_ovf_i;
        end
        default: step_up = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // Counter, direction flag and register B.
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      timer_count <= `COUNT_ZERO;
    else if (wr.en && hit(wr.addr, `OFF_COUNT))
      timer_count <= 16'(merge({16'h0, timer_count}, wr.data, wr.strb));
    else if (step_up)
      timer_count <= timer_count + 16'h0001;
    else if (step_dn)
      timer_count <= timer_count - 16'h0001;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      count_direction_flag <= `DIR_RST;
    else if (step_up)
      count_direction_flag <= 1'b1; // RULE7
    else if (step_dn)
      count_direction_flag <= 1'b0; // RULE7
  end

  assign capture_evt = capture_i && ctrl_reg[`CTRL_CAPTURE_BIT];

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      general_reg_b <= `COUNT_MAX;
    else if (capture_evt)
      general_reg_b <= timer_count; // RULE2
    else if (wr.en && hit(wr.addr, `OFF_GRB))
      general_reg_b <= 16'(merge({16'h0, general_reg_b}, wr.data, wr.strb));
  end

  // ****************************************************************
  // Status flags.
  // ****************************************************************
  assign flag_set[`IRQ_MATCH] = capture_evt || // RULE2
    (!ctrl_reg[`CTRL_CAPTURE_BIT] && timer_count == general_reg_b); // RULE1
  assign flag_set[`IRQ_OVF] = step_up && timer_count == `COUNT_MAX; // RULE3
  assign flag_set[`IRQ_UNF] = step_dn && timer_count == `COUNT_ZERO; // RULE4

  generate
    for (genvar g = 0; g < `NUM_FLAGS; g++)
    begin : g_flag
      logic sw_clear;
      logic hw_clear;
      assign sw_clear = wr.en && hit(wr.addr, `OFF_STATUS) && wr.strb[0] &&
                        !wr.data[flag_pos(g)] && armed_reg[g]; // RULE5
      if (g == `IRQ_MATCH)
      begin : g_xfer
        assign hw_clear = transfer_activate_i && match_b_interrupt_o &&
                          !ctrl_reg[`CTRL_TRANSFER_DISABLE_SELECT_BIT]; // RULE8
      end
      else
      begin : g_none
        assign hw_clear = 1'b0;
      end

      always_ff @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          flag_reg[g] <= 1'b0;
        else if (flag_set[g])
          flag_reg[g] <= 1'b1;
        else if (sw_clear || hw_clear)
          flag_reg[g] <= 1'b0; // RULE5
      end
      always_ff @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          armed_reg[g] <= 1'b0;
        else if (rd_en && hit(rd_addr, `OFF_STATUS))
          armed_reg[g] <= flag_reg[g]; // RULE5
        else if ((wr.en && hit(wr.addr, `OFF_STATUS)) || hw_clear)
          armed_reg[g] <= 1'b0;
      end
      always_ff @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          irq_stat_reg[g] <= 1'b0;
        else if (flag_set[g])
          irq_stat_reg[g] <= 1'b1;
        else if (wr.en && hit(wr.addr, `OFF_IRQ_CLR) && wr.strb[0] && wr.data[g])
          irq_stat_reg[g] <= 1'b0;
      end
    end
  endgenerate

  // ****************************************************************
  // Interrupt enable and outputs.
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      irq_en_reg <= 3'h0;
    else if (wr.en && hit(wr.addr, `OFF_IRQ_EN) && wr.strb[0])
      irq_en_reg <= wr.data[`NUM_FLAGS-1:0];
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      irq_o <= 1'b0;
      match_b_interrupt_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(irq_stat_reg & irq_en_reg);
      match_b_interrupt_o <= flag_reg[`IRQ_MATCH] && irq_en_reg[`IRQ_MATCH];
    end
  end

endmodule : timer_channel_status_flags

// [tb/timer_channel_status_flags_props.sv]
// Checker of the register bus timing of the timer channel.
`timescale 1ns/10ps
`include "timer_channel_status_flags_regs.svh"
module timer_channel_status_flags_props
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic s_axi_awvalid_i,
  input timer_channel_pkg::axil_addr_t s_axi_aw_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rready_i
);
  // ********************************************************
  // Helper state and bus properties.
  // ********************************************************
  logic hit_reg;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      hit_reg <= 1'b1;
    else if (s_axi_awvalid_i && s_axi_awready_o)
      hit_reg <= (s_axi_aw_i.addr <= `OFF_IRQ_EN) && (s_axi_aw_i.addr[1:0] == 2'h0);
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  property p_aw_busy;
    s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o;
  endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("write address taken while busy");
  property p_b_late;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o;
  endproperty
  a_b_late: assert property (p_b_late) else $error("write answer timing");
  property p_b_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_done;
    s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write channel not freed");
  property p_r_fast;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
  endproperty
  a_r_fast: assert property (p_r_fast) else $error("read answer timing");
  property p_r_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_code;
    $rose(s_axi_bvalid_o) |-> s_axi_bresp_o == (hit_reg ? `RESP_OKAY : `RESP_SLVERR);
  endproperty
  a_b_code: assert property (p_b_code) else $error("write response code");
  property p_r_zero;
    s_axi_rvalid_o && s_axi_rresp_o != `RESP_OKAY |-> s_axi_rdata_o == 32'h0000_0000;
  endproperty
  a_r_zero: assert property (p_r_zero) else $error("error read data not zero");
endmodule : timer_channel_status_flags_props
bind timer_channel_status_flags timer_channel_status_flags_props i_timer_channel_status_flags_props
(
  .clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_aw_i(s_axi_aw_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rready_i(s_axi_rready_i)
);

// [tb/tb_top.sv]
// Self-checking testbench of the timer channel status flags.
`timescale 1ns/10ps
`include "timer_channel_status_flags_regs.svh"
module tb_top;
  localparam logic [31:0] all_m = 32'hFFFF_FFFF;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bry = 1'b0;
  logic arv = 1'b0;
  logic rry = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [1:0] ph = 2'h0;
  timer_channel_pkg::axil_addr_t aw = '0;
  timer_channel_pkg::axil_addr_t ar = '0;
  timer_channel_pkg::axil_wdata_t w = '0;
  logic awr, wrd, bv, arr, rv, irq, mbi;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int n_fail = 0;
  int n_tests = 0;

  timer_channel_status_flags i_timer_channel_status_flags
  (
    .clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awvalid_i(awv), .s_axi_aw_i(aw),
    .s_axi_awready_o(awr), .s_axi_wvalid_i(wv), .s_axi_w_i(w), .s_axi_wready_o(wrd),
    .s_axi_bvalid_o(bv), .s_axi_bresp_o(bresp), .s_axi_bready_i(bry),
    .s_axi_arvalid_i(arv), .s_axi_ar_i(ar), .s_axi_arready_o(arr), .s_axi_rvalid_o(rv),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rready_i(rry),
    .capture_i(ev[3]), .phase_a_i(ph[1]), .phase_b_i(ph[0]), .cascade_ovf_i(ev[1]),
    .cascade_unf_i(ev[2]), .transfer_activate_i(ev[0]), .match_b_interrupt_o(mbi),
    .irq_o(irq)
  );

  // ********************************************************
  // Bus tasks and comparison.
  // ********************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [31:0] resp(input logic [31:0] a);
    return {30'h0, (a <= `OFF_IRQ_EN && a[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR};
  endfunction : resp

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    aw <= '{addr: a, prot: 3'h0};
    w <= '{data: d, strb: 4'hF};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end
    while (!bv);
    bry <= 1'b0;
    check({30'h0, bresp}, resp(a));
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_i);
    ar <= '{addr: a, prot: 3'h0};
    arv <= 1'b1;
    rry <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (arr) arv <= 1'b0;
    end
    while (!rv);
    rry <= 1'b0;
    check(rdata & m, e);
    check({30'h0, rresp}, resp(a));
  endtask : rd

  task automatic pulse(input logic [3:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 4'h0;
  endtask : pulse

  task automatic phase(input logic [1:0] v);
    @(posedge clk_i);
    ph <= v;
    repeat (2) @(posedge clk_i);
  endtask : phase

  // ********************************************************
  // Scenarios.
  // ********************************************************
  task automatic t_reset;
    rd(`OFF_CTRL, all_m, 32'h0000_0000);
    rd(`OFF_GRB, all_m, 32'h0000_FFFF);
    rd(`OFF_STATUS, all_m, 32'h0000_0080);
    rd(`OFF_IRQ_EN, all_m, 32'h0000_0000);
    rd(32'h0000_001C, all_m, 32'h0000_0000);
    wr(32'h0000_001C, 32'h0000_0001);
  endtask : t_reset

  task automatic t_overflow;
    wr(`OFF_IRQ_EN, 32'h0000_0007);
    wr(`OFF_COUNT, 32'h0000_FFF0);
    wr(`OFF_CTRL, 32'h0000_0001);
    repeat (20) @(posedge clk_i);
    wr(`OFF_CTRL, 32'h0000_0000);
    rd(`OFF_STATUS, all_m, 32'h0000_0092);
    wr(`OFF_STATUS, 32'h0000_00FF);
    wr(`OFF_STATUS, 32'h0000_0000);
    rd(`OFF_STATUS, all_m, 32'h0000_0092);
    wr(`OFF_STATUS, 32'h0000_0000);
    rd(`OFF_STATUS, all_m, 32'h0000_0080);
    rd(`OFF_IRQ_STAT, all_m, 32'h0000_0003);
    check({31'h0, irq}, 32'h0000_0001);
    wr(`OFF_IRQ_CLR, 32'h0000_0007);
    rd(`OFF_IRQ_CLR, all_m, 32'h0000_0000);
    rd(`OFF_IRQ_STAT, all_m, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
  endtask : t_overflow

  task automatic t_cascade;
    wr(`OFF_IRQ_EN, 32'h0000_0000);
    wr(`OFF_COUNT, 32'h0000_0001);
    wr(`OFF_CTRL, 32'h0000_0005);
    pulse(4'h4);
    pulse(4'h4);
    rd(`OFF_COUNT, all_m, 32'h0000_FFFF);
    rd(`OFF_STATUS, 32'h0000_00B0, 32'h0000_0020);
    check({31'h0, irq}, 32'h0000_0000);
    wr(`OFF_IRQ_EN, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq}, 32'h0000_0001);
    pulse(4'h2);
    rd(`OFF_COUNT, all_m, 32'h0000_0000);
    rd(`OFF_STATUS, 32'h0000_00B0, 32'h0000_00B0);
  endtask : t_cascade

  task automatic t_phase;
    wr(`OFF_CTRL, 32'h0000_0003);
    wr(`OFF_COUNT, 32'h0000_0010);
    phase(2'h2);
    phase(2'h3);
    rd(`OFF_COUNT, all_m, 32'h0000_0012);
    rd(`OFF_STATUS, 32'h0000_0080, 32'h0000_0080);
    phase(2'h2);
    phase(2'h0);
    rd(`OFF_COUNT, all_m, 32'h0000_0010);
    rd(`OFF_STATUS, 32'h0000_0080, 32'h0000_0000);
  endtask : t_phase

  task automatic t_capture;
    wr(`OFF_CTRL, 32'h0000_000F);
    wr(`OFF_COUNT, 32'h0000_1234);
    rd(`OFF_STATUS, all_m, 32'h0000_0032);
    wr(`OFF_STATUS, 32'h0000_0000);
    wr(`OFF_IRQ_EN, 32'h0000_0001);
    pulse(4'h8);
    rd(`OFF_GRB, all_m, 32'h0000_1234);
    rd(`OFF_STATUS, 32'h0000_0002, 32'h0000_0002);
    check({31'h0, mbi}, 32'h0000_0001);
    pulse(4'h1);
    rd(`OFF_STATUS, 32'h0000_0002, 32'h0000_0000);
    wr(`OFF_CTRL, 32'h0000_001F);
    pulse(4'h8);
    pulse(4'h1);
    rd(`OFF_STATUS, 32'h0000_0002, 32'h0000_0002);
  endtask : t_capture

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    summarize();
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_overflow();
    t_cascade();
    t_phase();
    t_capture();
    summarize();
  end
endmodule : tb_top
